/* pkg/dsol_defines.vh */
`ifndef DSOL_DEFINES_VH
`define DSOL_DEFINES_VH
`define DSOL_CLK_PERIOD_NS 5
`define DSOL_LIMIT_MS 20
`define DSOL_MIN_ON_MS 100
`define DSOL_LIMIT_CYC (`DSOL_LIMIT_MS * 1000000 / `DSOL_CLK_PERIOD_NS)
`define DSOL_MIN_ON_CYC (`DSOL_MIN_ON_MS * 1000000 / `DSOL_CLK_PERIOD_NS)
`define DSOL_WARN_OFS 5
`define DSOL_CLEAR_OFS 8
`define DSOL_SAT_DISP 16'h270f
`define DSOL_INV_OFS 1000
`define DSOL_ROLE_NONE 3'h0
`define DSOL_ROLE_AUX1 3'h1
`define DSOL_ROLE_AUX2 3'h2
`define DSOL_ROLE_PID 3'h3
`define DSOL_ROLE_FB 3'h5
`define DSOL_SRC_UPDOWN 4'h7
`define DSOL_FN_FAR 11'd1
`define DSOL_FN_OL 11'd7
`define DSOL_FN_ARRIVAL_DELAYED_FLAG 11'd21
`define DSOL_FN_LIM 11'd22
`define DSOL_FN_OH 11'd28
`define DSOL_FN_LIFE 11'd30
`define DSOL_FN_REF 11'd33
`define DSOL_FN_LOW_SPEED_OUTPUT_FLAG 11'd35
`define DSOL_FN_OLP 11'd36
`define DSOL_FN_IDA 11'd37
`define DSOL_FN_IDB 11'd38
`define DSOL_FN_SWM 11'd49
`define DSOL_FN_BRK 11'd57
`define DSOL_FN_ALM 11'd99
`endif

/* rtl/dsol_timed_flag.v */
`timescale 1ns/100ps
// Qualified, stretched flag: sets after cond has held hold_cyc cycles,
// then stays set until min_cyc has passed and clr holds.
module dsol_timed_flag (
   input wire clk,
   input wire rst_b,
   input wire cond,
   input wire clr,
   input wire [31:0] hold_cyc,
   input wire [31:0] min_cyc,
   output reg flag_q
);
   reg [31:0] hold_q;
   reg [31:0] on_q;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= 32'h0;
         on_q <= 32'h0;
         flag_q <= 1'b0;
      end else begin
         if (!cond) begin
            hold_q <= 32'h0;
         end else if (hold_q < hold_cyc) begin
            hold_q <= hold_q + 32'h1;
         end
         if (!flag_q) begin
            on_q <= 32'h0;
            if (cond && hold_q >= hold_cyc) begin
               flag_q <= 1'b1;
            end
         end else begin
            if (on_q < min_cyc) begin
               on_q <= on_q + 32'h1;
            end
            if (on_q >= min_cyc && clr) begin
               flag_q <= 1'b0;
            end
         end
      end
   end
endmodule

/* rtl/dsol_status_out.v */
`timescale 1ns/100ps
`include "dsol_defines.vh"
module dsol_status_out (
   input wire clk,
   input wire rst_b,
   input wire [15:0] out_freq,
   input wire [15:0] ref_freq,
   input wire [15:0] arrival_window,
   input wire [31:0] arrival_delay_time,
   input wire limit_active_pin,
   input wire [7:0] heatsink_temp,
   input wire [7:0] heatsink_trip_temp,
   input wire life_expired_pin,
   input wire ref_loss_pin,
   input wire [15:0] start_freq,
   input wire dc_brake_pin,
   input wire overload_guard_pin,
   input wire [15:0] out_current,
   input wire [15:0] current_level_a,
   input wire [31:0] current_timer_a,
   input wire [15:0] current_level_b,
   input wire [31:0] current_timer_b,
   input wire motor_select_cmd,
   input wire brake_request_pin,
   input wire fault_trip_pin,
   input wire [15:0] speed_display_coef,
   input wire [15:0] feed_time,
   input wire [15:0] energy_display_coef,
   input wire energy_tick,
   input wire [15:0] energy_increment,
   input wire analog_in_b_type,
   input wire [2:0] analog_in_a_role,
   input wire [2:0] analog_in_b_current_role,
   input wire [2:0] analog_in_b_voltage_role,
   input wire [3:0] primary_freq_source,
   input wire [10:0] out_code_0,
   input wire [10:0] out_code_1,
   input wire [10:0] out_code_2,
   output reg arrival_flag,
   output reg arrival_delayed_flag,
   output reg limit_hold_flag,
   output reg heatsink_warn,
   output reg life_flag,
   output reg command_loss_flag,
   output reg low_speed_output_flag,
   output reg overload_guard_flag,
   output reg current_detect_a,
   output reg current_detect_b,
   output reg overload_warn,
   output reg second_motor_flag,
   output reg brake_cmd,
   output reg fault_flag,
   output reg [31:0] line_speed,
   output reg [31:0] energy_display,
   output reg analog_b_voltage_mode,
   output reg [1:0] aux1_src,
   output reg [1:0] aux2_src,
   output reg [1:0] pid_cmd_src,
   output reg [1:0] pid_fb_src,
   output reg [2:0] term_out
);
   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   // Flag pins come from other logic with no shared clock, so each passes
   // three stages and changes only when the last two agree.
   localparam NP = 9;
   wire [NP-1:0] pin_raw = {limit_active_pin, life_expired_pin,
      ref_loss_pin, dc_brake_pin, overload_guard_pin, motor_select_cmd,
      brake_request_pin, fault_trip_pin, energy_tick};
   wire [NP-1:0] pin_q;
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi = gi + 1) begin : g_sync
         // Each stage is a scalar of its own loop pass, so every flip-flop
         // has a single process driving it.
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg agree_q;
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               agree_q <= 1'b0;
            end else begin
               s1_q <= pin_raw[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  agree_q <= s3_q;
               end
            end
         end
         assign pin_q[gi] = agree_q;
      end
   endgenerate
   wire limit_s = pin_q[8];
   wire life_s = pin_q[7];
   wire refloss_s = pin_q[6];
   wire dcb_s = pin_q[5];
   wire olp_s = pin_q[4];
   wire msel_s = pin_q[3];
   wire brk_s = pin_q[2];
   wire fault_s = pin_q[1];
   wire tick_s = pin_q[0];
   reg tick_d1_q;

   // ****************************************************
   // Comparisons
   // ****************************************************
   wire [16:0] freq_diff = (out_freq >= ref_freq) ?
      {1'b0, out_freq - ref_freq} : {1'b0, ref_freq - out_freq};
   wire in_band = freq_diff <= {1'b0, arrival_window};
   wire [8:0] warn_on_lvl = {1'b0, heatsink_trip_temp} - 9'd`DSOL_WARN_OFS;
   wire [8:0] warn_off_lvl = {1'b0, heatsink_trip_temp} - 9'd`DSOL_CLEAR_OFS;
   wire over_a = out_current > current_level_a;
   wire over_b = out_current > current_level_b;
   // 90 percent release
   // Ten times the current against nine times the level avoids a divider
   // and keeps the release point exact.
   wire [19:0] cur_x10 = {4'h0, out_current} * 20'd10;
   wire below_a = cur_x10 < ({4'h0, current_level_a} * 20'd9);
   wire below_b = cur_x10 < ({4'h0, current_level_b} * 20'd9);

   // ****************************************************
   // Timed flags
   // ****************************************************
   // The 20 ms and 100 ms counts assume the 200 MHz clock; a slower clock
   // stretches both in proportion.
   wire arrival_delayed_flag_w;
   wire lim_w;
   wire olp_w;
   wire ida_w;
   wire idb_w;
   wire [31:0] min_on = `DSOL_MIN_ON_CYC;
   dsol_timed_flag u_arrival_delayed_flag (.clk(clk), .rst_b(rst_b), .cond(in_band),
      .clr(!in_band), .hold_cyc(arrival_delay_time), .min_cyc(32'h0),
      .flag_q(arrival_delayed_flag_w));
   dsol_timed_flag u_lim (.clk(clk), .rst_b(rst_b), .cond(limit_s),
      .clr(!limit_s), .hold_cyc(`DSOL_LIMIT_CYC), .min_cyc(32'h0),
      .flag_q(lim_w));
   dsol_timed_flag u_olp (.clk(clk), .rst_b(rst_b), .cond(olp_s),
      .clr(!olp_s), .hold_cyc(32'h0), .min_cyc(min_on),
      .flag_q(olp_w));
   dsol_timed_flag u_ida (.clk(clk), .rst_b(rst_b), .cond(over_a),
      .clr(below_a), .hold_cyc(current_timer_a), .min_cyc(min_on),
      .flag_q(ida_w));
   dsol_timed_flag u_idb (.clk(clk), .rst_b(rst_b), .cond(over_b),
      .clr(below_b), .hold_cyc(current_timer_b), .min_cyc(min_on),
      .flag_q(idb_w));

   // ****************************************************
   // Status flags
   // ****************************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         arrival_flag <= 1'b0;
         arrival_delayed_flag <= 1'b0;
         limit_hold_flag <= 1'b0;
         heatsink_warn <= 1'b0;
         life_flag <= 1'b0;
         command_loss_flag <= 1'b0;
         low_speed_output_flag <= 1'b0;
         overload_guard_flag <= 1'b0;
         current_detect_a <= 1'b0;
         current_detect_b <= 1'b0;
         overload_warn <= 1'b0;
         second_motor_flag <= 1'b0;
         brake_cmd <= 1'b0;
         fault_flag <= 1'b0;
      end else begin
         arrival_flag <= in_band;
         arrival_delayed_flag <= arrival_delayed_flag_w;
         limit_hold_flag <= lim_w;
         if ({1'b0, heatsink_temp} > warn_on_lvl) begin
            heatsink_warn <= 1'b1;
         end else if ({1'b0, heatsink_temp} <= warn_off_lvl) begin
            heatsink_warn <= 1'b0;
         end
         life_flag <= life_s;
         command_loss_flag <= refloss_s;
         low_speed_output_flag <= (out_freq <= start_freq) || dcb_s;
         overload_guard_flag <= olp_w;
         current_detect_a <= ida_w;
         current_detect_b <= idb_w;
         overload_warn <= over_a;
         second_motor_flag <= msel_s;
         brake_cmd <= brk_s;
         fault_flag <= fault_s;
      end
   end

   // ****************************************************
   // Terminal routing
   // ****************************************************
   // A code that names no function leaves its terminal low, or high in the
   // inverted form, so a mistyped code shows as a steady level.
   wire [2:0] term_d;
   wire [13:0] fn_vec = {fault_flag, brake_cmd, second_motor_flag,
      current_detect_b, current_detect_a, overload_guard_flag,
      low_speed_output_flag, command_loss_flag, life_flag, heatsink_warn,
      limit_hold_flag, arrival_delayed_flag, overload_warn, arrival_flag};
   wire [10:0] codes [0:2];
   assign codes[0] = out_code_0;
   assign codes[1] = out_code_1;
   assign codes[2] = out_code_2;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_term
         wire inv = codes[gi] >= 11'd`DSOL_INV_OFS;
         wire [10:0] base = inv ? codes[gi] - 11'd`DSOL_INV_OFS : codes[gi];
         reg sel;
         always @* begin
            case (base)
               `DSOL_FN_FAR: sel = fn_vec[0];
               `DSOL_FN_OL: sel = fn_vec[1];
               `DSOL_FN_ARRIVAL_DELAYED_FLAG: sel = fn_vec[2];
               `DSOL_FN_LIM: sel = fn_vec[3];
               `DSOL_FN_OH: sel = fn_vec[4];
               `DSOL_FN_LIFE: sel = fn_vec[5];
               `DSOL_FN_REF: sel = fn_vec[6];
               `DSOL_FN_LOW_SPEED_OUTPUT_FLAG: sel = fn_vec[7];
               `DSOL_FN_OLP: sel = fn_vec[8];
               `DSOL_FN_IDA: sel = fn_vec[9];
               `DSOL_FN_IDB: sel = fn_vec[10];
               `DSOL_FN_SWM: sel = fn_vec[11];
               `DSOL_FN_BRK: sel = fn_vec[12];
               `DSOL_FN_ALM: sel = fn_vec[13];
               default: sel = 1'b0;
            endcase
         end
         assign term_d[gi] = sel ^ inv;
      end
   endgenerate
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         term_out <= 3'h0;
      end else begin
         term_out <= term_d;
      end
   end

   // ****************************************************
   // Displays
   // ****************************************************
   // Line speed is the coefficient times the output frequency; a feed time at or above
   // the saturated value, or a stopped drive (zero output frequency), forces the saturated value.
   reg [31:0] energy_acc_q;
   wire [31:0] lspeed_w = {16'h0, speed_display_coef} * {16'h0, out_freq};
   wire [47:0] edisp_w = {16'h0, energy_acc_q} * {32'h0, energy_display_coef};
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         energy_acc_q <= 32'h0;
         tick_d1_q <= 1'b0;
         energy_display <= 32'h0;
         line_speed <= 32'h0;
      end else begin
         tick_d1_q <= tick_s;
         if (energy_display_coef == 16'h0) begin
            energy_acc_q <= 32'h0;
         end else if (tick_s && !tick_d1_q) begin
            energy_acc_q <= energy_acc_q + {16'h0, energy_increment};
         end
         energy_display <= edisp_w[31:0];
         if (feed_time >= `DSOL_SAT_DISP || out_freq == 16'h0) begin
            line_speed <= {16'h0, `DSOL_SAT_DISP};
         end else begin
            line_speed <= lspeed_w;
         end
      end
   end

   // ****************************************************
   // Analog role selection
   // ****************************************************
   // Sources: 0 none, 1 input A, 2 input B current, 3 input B voltage.
   wire [2:0] role_bc = analog_in_b_type ? `DSOL_ROLE_NONE :
      analog_in_b_current_role;
   wire [2:0] role_bv = analog_in_b_type ? analog_in_b_voltage_role :
      `DSOL_ROLE_NONE;
   // Up/down control takes no analog trim, so both auxiliary selections
   // read as none while it is the frequency source.
   wire aux_ok = primary_freq_source != `DSOL_SRC_UPDOWN;
   function [1:0] pick;
      input [2:0] code;
      input [2:0] ra;
      input [2:0] rbc;
      input [2:0] rbv;
      begin
         if (ra == code) begin
            pick = 2'h1;
         end else if (rbc == code) begin
            pick = 2'h2;
         end else if (rbv == code) begin
            pick = 2'h3;
         end else begin
            pick = 2'h0;
         end
      end
   endfunction
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         analog_b_voltage_mode <= 1'b0;
         aux1_src <= 2'h0;
         aux2_src <= 2'h0;
         pid_cmd_src <= 2'h0;
         pid_fb_src <= 2'h0;
      end else begin
         analog_b_voltage_mode <= analog_in_b_type;
         aux1_src <= aux_ok ? pick(`DSOL_ROLE_AUX1, analog_in_a_role,
            role_bc, role_bv) : 2'h0;
         aux2_src <= aux_ok ? pick(`DSOL_ROLE_AUX2, analog_in_a_role,
            role_bc, role_bv) : 2'h0;
         pid_cmd_src <= pick(`DSOL_ROLE_PID, analog_in_a_role, role_bc,
            role_bv);
         pid_fb_src <= pick(`DSOL_ROLE_FB, analog_in_a_role, role_bc,
            role_bv);
      end
   end
endmodule

/* test/dsol_ext_equip.sv */
`timescale 1ns/100ps
// Terminal-side equipment: latches what the three output terminals show.
module dsol_ext_equip (
   input wire clk,
   input wire rst_b,
   input wire [2:0] term_out,
   output reg [2:0] seen_q
);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_q <= 3'h0;
      end else begin
         seen_q <= term_out;
      end
   end
endmodule

/* test/dsol_checker_assertions.sv */
`timescale 1ns/100ps
module dsol_checker (
   input wire clk,
   input wire rst_b,
   input wire [15:0] out_freq,
   input wire [15:0] ref_freq,
   input wire [15:0] arrival_window,
   input wire arrival_flag,
   input wire arrival_delayed_flag,
   input wire [7:0] heatsink_temp,
   input wire [7:0] heatsink_trip_temp,
   input wire heatsink_warn,
   input wire fault_trip_pin,
   input wire fault_flag,
   input wire current_detect_a,
   input wire overload_guard_flag,
   input wire [3:0] primary_freq_source,
   input wire [1:0] aux1_src,
   input wire [1:0] aux2_src,
   input wire [15:0] energy_display_coef,
   input wire [31:0] energy_display,
   input wire [15:0] feed_time,
   input wire [31:0] line_speed
);
   wire [15:0] dif = (out_freq > ref_freq) ? out_freq - ref_freq :
      ref_freq - out_freq;
   wire inb = dif < arrival_window;
   wire outb = dif > arrival_window;
   wire hot = {1'b0, heatsink_temp} + 9'h005 > {1'b0, heatsink_trip_temp};
   wire cold = {1'b0, heatsink_temp} + 9'h008 <= {1'b0, heatsink_trip_temp};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence band_in;
      inb ##1 inb;
   endsequence
   sequence fault_steady;
      $stable(fault_trip_pin)[*8];
   endsequence
   sequence coef_back;
      (energy_display_coef == 16'h0000)[*3] ##1
         (energy_display_coef != 16'h0000);
   endsequence
   a_band_in: assert property (band_in |-> arrival_flag)
      else $error("arrival flag missing inside band");
   a_band_out: assert property (outb ##1 outb |-> !arrival_flag)
      else $error("arrival flag outside band");
   a_delay_after: assert property (
      $rose(arrival_delayed_flag) |-> $past(arrival_flag))
      else $error("delayed arrival before arrival");
   a_heat_set: assert property (hot ##1 hot |-> heatsink_warn)
      else $error("heat warning not set");
   a_heat_clear: assert property (cold ##1 cold |-> !heatsink_warn)
      else $error("heat warning not cleared");
   a_fault_follow: assert property (
      fault_steady |-> fault_flag == fault_trip_pin)
      else $error("fault flag does not follow trip");
   a_detect_hold: assert property (
      $rose(current_detect_a) |=> current_detect_a[*8])
      else $error("detect flag too short");
   a_updown_aux: assert property (
      (primary_freq_source == 4'h7)[*2] |-> aux1_src == 2'h0 &&
      aux2_src == 2'h0)
      else $error("aux input used under up-down");
   a_energy_clear: assert property (
      (energy_display_coef == 16'h0000)[*3] |-> energy_display == 0)
      else $error("energy not cleared");
   a_speed_sat: assert property (
      (feed_time >= 16'h270f)[*4] |-> line_speed == 32'h270f)
      else $error("line speed not saturated");
   a_energy_zeroed: assert property (
      coef_back |=> energy_display == 32'h0)
      else $error("energy kept after zero coefficient");
   a_guard_hold: assert property (
      $rose(overload_guard_flag) |=> overload_guard_flag[*8])
      else $error("overload guard flag too short");
endmodule
bind dsol_status_out dsol_checker i_dsol_checker (.*);

/* test/testbench.sv */
`timescale 1ns/100ps
`include "dsol_defines.vh"
module testbench;
   reg clk, rst_b, limit_active_pin, life_expired_pin, ref_loss_pin;
   reg dc_brake_pin, overload_guard_pin, motor_select_cmd;
   reg brake_request_pin, fault_trip_pin, energy_tick, analog_in_b_type;
   reg [15:0] out_freq, ref_freq, arrival_window, start_freq, out_current;
   reg [15:0] current_level_a, current_level_b, speed_display_coef;
   reg [15:0] feed_time, energy_display_coef, energy_increment;
   reg [31:0] arrival_delay_time, current_timer_a, current_timer_b;
   reg [7:0] heatsink_temp, heatsink_trip_temp;
   reg [2:0] analog_in_a_role, analog_in_b_current_role;
   reg [2:0] analog_in_b_voltage_role;
   reg [3:0] primary_freq_source;
   reg [10:0] out_code_0, out_code_1, out_code_2;
   wire arrival_flag, arrival_delayed_flag, limit_hold_flag, heatsink_warn;
   wire life_flag, command_loss_flag, low_speed_output_flag;
   wire overload_guard_flag, current_detect_a, current_detect_b;
   wire overload_warn, second_motor_flag, brake_cmd, fault_flag;
   wire analog_b_voltage_mode;
   wire [31:0] line_speed, energy_display;
   wire [1:0] aux1_src, aux2_src, pid_cmd_src, pid_fb_src;
   wire [2:0] term_out, seen_q;
   integer mismatches, checks_done, i, n, v;
   localparam [39:0] HT = {8'd96, 8'd93, 8'd92, 8'd95, 8'd96};
   localparam [4:0] HX = 5'b11001;
   dsol_status_out i_dsol_status_out (.*);
   dsol_ext_equip i_dsol_ext_equip (.clk(clk), .rst_b(rst_b),
      .term_out(term_out), .seen_q(seen_q));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ***************
   // Helpers
   // ***************
   task cyc(input integer k);
      repeat (k) @(negedge clk);
   endtask
   task chk_b(input exp, input got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t flag exp %b got %b", $time, exp, got);
         end
      end
   endtask
   task chk_w(input [31:0] exp, input [31:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t value exp %0h got %0h", $time, exp, got);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   function [1:0] src_of(input [2:0] r);
      begin
         if (analog_in_a_role == r) src_of = 2'h1;
         else if (!analog_in_b_type && analog_in_b_current_role == r)
            src_of = 2'h2;
         else if (analog_in_b_type && analog_in_b_voltage_role == r)
            src_of = 2'h3;
         else src_of = 2'h0;
      end
   endfunction
   function [2:0] role_rnd(input integer k);
      role_rnd = (k == 4) ? 3'h5 : k[2:0];
   endfunction
   function [15:0] adif(input [15:0] a, input [15:0] b);
      adif = (a > b) ? a - b : b - a;
   endfunction
   // ***************
   // Main sequence
   // ***************
   initial begin
      {limit_active_pin, life_expired_pin, ref_loss_pin, dc_brake_pin} = 0;
      {overload_guard_pin, motor_select_cmd, brake_request_pin} = 0;
      {fault_trip_pin, energy_tick, analog_in_b_type} = 0;
      {analog_in_a_role, analog_in_b_current_role} = 0;
      analog_in_b_voltage_role = 3'h0;
      primary_freq_source = 4'h0;
      {out_code_0, out_code_1, out_code_2} = 0;
      out_freq = 16'h07d0;
      ref_freq = 16'h03e8;
      arrival_window = 16'h0032;
      start_freq = 16'h0064;
      out_current = 16'h0000;
      current_level_a = 16'h0064;
      current_level_b = 16'h0064;
      current_timer_a = 32'h0000000a;
      current_timer_b = 32'h0000000a;
      arrival_delay_time = 32'h00000014;
      {speed_display_coef, feed_time} = 0;
      energy_display_coef = 16'h0001;
      energy_increment = 16'h0005;
      heatsink_temp = 8'h14;
      heatsink_trip_temp = 8'h64;
      mismatches = 0;
      checks_done = 0;
      rst_b = 1'b0;
      n = $urandom(64);
      cyc(5);
      rst_b = 1'b1;
      cyc(4);
      chk_b(1'b0, arrival_flag);
      out_freq = 16'h0410;
      cyc(1);
      chk_b(1'b1, arrival_flag);
      n = 1;
      while (n < 100 && arrival_delayed_flag !== 1'b1) begin
         cyc(1);
         n = n + 1;
      end
      if (n >= 100) begin
         mismatches = mismatches + 1;
         summarize;
      end
      chk_b(1'b1, n >= 20 && n <= 24);
      $display("test arrival done");
      for (i = 0; i < 5; i = i + 1) begin
         heatsink_temp = HT[8 * (4 - i) +: 8];
         cyc(3);
         chk_b(HX[4 - i], heatsink_warn);
      end
      $display("test heat sink done");
      for (v = 1; v >= 0; v = v - 1) begin
         {motor_select_cmd, brake_request_pin, fault_trip_pin} = {3{v[0]}};
         {ref_loss_pin, life_expired_pin, dc_brake_pin} = {3{v[0]}};
         cyc(10);
         chk_b(v[0], second_motor_flag);
         chk_b(v[0], brake_cmd);
         chk_b(v[0], fault_flag);
         chk_b(v[0], command_loss_flag);
         chk_b(v[0], life_flag);
         chk_b(v[0], low_speed_output_flag);
      end
      out_freq = 16'h0032;
      cyc(3);
      chk_b(1'b1, low_speed_output_flag);
      out_freq = 16'h0410;
      overload_guard_pin = 1'b1;
      limit_active_pin = 1'b1;
      cyc(7);
      chk_b(1'b1, overload_guard_flag);
      overload_guard_pin = 1'b0;
      cyc(40);
      chk_b(1'b1, overload_guard_flag);
      chk_b(1'b0, limit_hold_flag);
      limit_active_pin = 1'b0;
      $display("test pins done");
      out_code_0 = `DSOL_FN_FAR;
      out_code_1 = `DSOL_FN_FAR + 11'd1000;
      out_code_2 = `DSOL_FN_ALM + 11'd1000;
      cyc(4);
      chk_w(32'h5, {29'h0, term_out});
      chk_w(32'h5, {29'h0, seen_q});
      out_code_0 = `DSOL_FN_IDA;
      out_code_1 = `DSOL_FN_IDB;
      out_code_2 = `DSOL_FN_OL;
      out_current = 16'h01f4;
      cyc(5);
      chk_w(32'h4, {29'h0, term_out});
      cyc(15);
      chk_w(32'h7, {29'h0, term_out});
      chk_b(1'b1, overload_warn);
      current_level_a = 16'h0258;
      cyc(4);
      chk_b(1'b0, overload_warn);
      chk_b(1'b1, current_detect_a);
      chk_b(1'b1, current_detect_b);
      $display("test routing done");
      for (i = 0; i < 60; i = i + 1) begin
         analog_in_a_role = role_rnd($urandom % 5);
         analog_in_b_current_role = role_rnd($urandom % 5);
         analog_in_b_voltage_role = role_rnd($urandom % 5);
         analog_in_b_type = $urandom % 2;
         primary_freq_source = $urandom % 8;
         cyc(3);
         chk_b(analog_in_b_type, analog_b_voltage_mode);
         n = (primary_freq_source == `DSOL_SRC_UPDOWN);
         chk_w(n ? 0 : src_of(`DSOL_ROLE_AUX1), aux1_src);
         chk_w(n ? 0 : src_of(`DSOL_ROLE_AUX2), aux2_src);
         chk_w(src_of(`DSOL_ROLE_PID), pid_cmd_src);
         chk_w(src_of(`DSOL_ROLE_FB), pid_fb_src);
      end
      $display("test roles done");
      for (v = 0; v < 2; v = v + 1) begin
         energy_display_coef = 16'h0000;
         energy_tick = v[0];
         cyc(8);
         chk_w(0, energy_display);
         energy_tick = 1'b0;
         energy_display_coef = 16'h0003;
         cyc(8);
         chk_w(0, energy_display);
      end
      energy_tick = 1'b1;
      cyc(8);
      chk_w(32'hf, energy_display);
      feed_time = 16'h270f;
      cyc(5);
      chk_w(`DSOL_SAT_DISP, line_speed);
      feed_time = 16'h0000;
      out_freq = 16'h0000;
      cyc(5);
      chk_w(`DSOL_SAT_DISP, line_speed);
      for (i = 0; i < 5; i = i + 1) begin
         speed_display_coef = $urandom % 100;
         out_freq = 16'h0001 + $urandom % 1000;
         cyc(2);
         chk_w(speed_display_coef * out_freq, line_speed);
      end
      $display("test displays done");
      for (i = 0; i < 300; i = i + 1) begin
         out_freq = $urandom % 2000;
         ref_freq = $urandom % 2000;
         arrival_window = $urandom % 300;
         heatsink_trip_temp = 20 + $urandom % 200;
         heatsink_temp = $urandom % 250;
         out_current = $urandom % 1000;
         fault_trip_pin = $urandom % 2;
         limit_active_pin = $urandom % 2;
         overload_guard_pin = $urandom % 2;
         primary_freq_source = $urandom % 8;
         energy_display_coef = $urandom % 3;
         energy_tick = $urandom % 2;
         cyc(2);
         n = adif(out_freq, ref_freq);
         if (n != arrival_window)
            chk_b(n < arrival_window, arrival_flag);
         if (heatsink_temp + 5 > heatsink_trip_temp)
            chk_b(1'b1, heatsink_warn);
         if (heatsink_temp + 8 <= heatsink_trip_temp)
            chk_b(1'b0, heatsink_warn);
         chk_b(1'b0, limit_hold_flag);
         chk_b(1'b1, overload_guard_flag);
      end
      $display("test random done");
      summarize;
   end
endmodule
